// ### design/option_byte_configuration.sv
// Configuration word store, one-time programming and option decode.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [RULE_01] Programming only while programming voltage present.
// [RULE_02] Two option bytes form one 16-bit word.
// [RULE_03] Blank parts hold all-zero configuration.
// [RULE_04] Word has no address; programming mode only.
// [RULE_05] Mask parts: fixed word, no read access.
// [RULE_06] Each bit programs once; later changes rejected.
// [RULE_07] Programmer writes reserved bits as documented.
// [RULE_08] Bit 9 allows stop with watchdog, NMI high.
// [RULE_09] Bit 8 enables low-voltage detector.
// [RULE_10] Bit 7 blocks external program memory reads.
// [RULE_11] Bit 6 selects RC oscillator over crystal.
// [RULE_12] Bit 3 enables NMI pin pull-up.
// [RULE_13] Bit 2 enables timer pin pull-up.
// [RULE_14] Bit 1 selects hardware-enabled watchdog.
// [RULE_15] Bit 0 enables oscillator safeguard.
// [RULE_16] Default word needed for lowest consumption.
// [RULE_17] Outputs latched during reset, constant afterwards.
module option_byte_configuration
  import option_cfg_pkg::*;
#(
  parameter bit MASK_CODED = 1'b0,
  parameter logic [15:0] MASK_WORD = 16'h0010
)
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic prog_voltage_present,
  input wire logic prog_write,
  input wire logic [15:0] prog_wdata,
  input wire logic prog_read,
  output logic [15:0] prog_rdata,
  output logic prog_done,
  output logic prog_rejected,
  input wire logic watchdog_active,
  input wire logic nmi_pin,
  output logic stop_with_watchdog_ext_control,
  output logic stop_allowed,
  output logic low_voltage_detect_enable,
  output logic readout_protect,
  output logic osc_rc_select,
  output logic nmi_pin_pullup_enable,
  output logic timer_pin_pullup_enable,
  output logic hardware_watchdog_select,
  output logic osc_safeguard_enable
);

  ////////////////////////////////////////////////////////////////////////////
  logic rst_meta;
  logic rst_sync;
  logic vpp_meta;
  logic vpp_sync;
  // Storage is non-volatile: the cells survive reset, so they use no reset.
  // Simulation starts from the blank all-zero state.
  logic [15:0] stored = WORD_RESET; // RULE_03
  logic [15:0] active;
  logic [15:0] next_stored;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // The programming voltage comes from a pin, so it is synchronised first.
  always_ff @(posedge mclk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      vpp_meta <= 1'b0;
      vpp_sync <= 1'b0;
    end
    else
    begin
      vpp_meta <= prog_voltage_present;
      vpp_sync <= vpp_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // A bit once set can never be cleared, which models one-shot cells; a
  // write that would clear a programmed bit, or a second write, is refused.
  logic written = 1'b0;
  logic write_ok;
  assign write_ok = vpp_sync && prog_write && !MASK_CODED && !written &&
                    ((stored & ~prog_wdata) == 16'h0000); // RULE_06
  assign next_stored = stored | prog_wdata; // RULE_02

  always_ff @(posedge mclk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      prog_done <= 1'b0;
      prog_rejected <= 1'b0;
    end
    else
    begin
      prog_done <= write_ok; // RULE_01
      prog_rejected <= prog_write && !write_ok; // RULE_06
    end
  end

  always_ff @(posedge mclk)
  begin
    if (write_ok) // RULE_01
    begin
      stored <= next_stored; // RULE_06
      written <= 1'b1; // RULE_06
    end
  end

  // Readable only in programming mode and never on mask-coded parts.
  always_ff @(posedge mclk or negedge rst_sync)
  begin
    if (!rst_sync)
      prog_rdata <= 16'h0000;
    else if (vpp_sync && prog_read && !MASK_CODED) // RULE_04 RULE_05
      prog_rdata <= stored;
    else
      prog_rdata <= 16'h0000; // RULE_05
  end

  ////////////////////////////////////////////////////////////////////////////
  // Active copy is taken while reset is held and frozen after release, so a
  // program pass during operation only takes effect at the next reset.
  always_ff @(posedge mclk)
  begin
    if (!rst_sync)
      active <= MASK_CODED ? MASK_WORD : stored; // RULE_17 RULE_05
  end

  always_ff @(posedge mclk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      stop_with_watchdog_ext_control <= 1'b0;
      low_voltage_detect_enable <= 1'b0;
      readout_protect <= 1'b0;
      osc_rc_select <= 1'b0;
      nmi_pin_pullup_enable <= 1'b0;
      timer_pin_pullup_enable <= 1'b0;
      hardware_watchdog_select <= 1'b0;
      osc_safeguard_enable <= 1'b0;
    end
    else
    begin
      stop_with_watchdog_ext_control <= active[BIT_STOP_EXT]; // RULE_08
      low_voltage_detect_enable <= active[BIT_LVD]; // RULE_09
      readout_protect <= active[BIT_PROTECT]; // RULE_10
      osc_rc_select <= active[BIT_OSC]; // RULE_11
      nmi_pin_pullup_enable <= active[BIT_NMI_PULL]; // RULE_12
      timer_pin_pullup_enable <= active[BIT_TIMER_PIN_PULLUP_ENABLE]; // RULE_13
      hardware_watchdog_select <= active[BIT_HW_WDG]; // RULE_14
      osc_safeguard_enable <= active[BIT_OSG]; // RULE_15
    end
  end

  // The NMI level is assumed already synchronous to mclk.
  assign stop_allowed = !watchdog_active ||
                        (stop_with_watchdog_ext_control && nmi_pin); // RULE_08

endmodule
`default_nettype wire

// ### design/option_cfg_pkg.sv
// Constants for the one-time-programmable configuration word block.
package option_cfg_pkg;
  localparam int unsigned WORD_W = 16;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [15:0] RESERVED_ZERO_MASK = 16'hfc20;
  localparam logic [15:0] RESERVED_ONE_MASK = 16'h0010;
  localparam int unsigned BIT_STOP_EXT = 9;
  localparam int unsigned BIT_LVD = 8;
  localparam int unsigned BIT_PROTECT = 7;
  localparam int unsigned BIT_OSC = 6;
  localparam int unsigned BIT_NMI_PULL = 3;
  localparam int unsigned BIT_TIMER_PIN_PULLUP_ENABLE = 2;
  localparam int unsigned BIT_HW_WDG = 1;
  localparam int unsigned BIT_OSG = 0;
endpackage

// ### bench/option_prog_tool.sv
// Programming tool model that burns the option word.
`timescale 1ns/1ps
`default_nettype none
module option_prog_tool
  import option_cfg_pkg::*;
(
  input wire logic mclk,
  output logic vpp,
  output logic wr,
  output logic [15:0] wd
);
  initial {vpp, wr, wd} = 18'h00000;
  // The device never checks reserved bits, so the tool fixes them.
  task automatic burn(input logic [15:0] w, input logic v);
    @(negedge mclk) vpp = v;
    repeat (4) @(negedge mclk);
    wr = 1'b1;
    wd = w & ~RESERVED_ZERO_MASK | RESERVED_ONE_MASK;
    @(negedge mclk) wr = 1'b0;
    wd = ~wd;
  endtask
endmodule
`default_nettype wire

// ### bench/option_byte_configuration_assertions.sv
// Port checker for the option word block.
`timescale 1ns/1ps
`default_nettype none
module option_cfg_chk (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic prog_voltage_present,
  input wire logic prog_write,
  input wire logic prog_read,
  input wire logic prog_done,
  input wire logic prog_rejected,
  input wire logic watchdog_active,
  input wire logic nmi_pin,
  input wire logic stop_allowed,
  input wire logic stop_with_watchdog_ext_control,
  input wire logic [15:0] prog_rdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Never reset: the stored word outlives resets, so one acceptance per life.
  logic seen = 1'b0;
  always @(posedge mclk) seen <= seen | prog_done;
  a_done_src: assert property (prog_done |-> $past(prog_write)) else $error("done");
  a_nak_src: assert property (prog_rejected |-> $past(prog_write)) else $error("nak");
  a_one_win: assert property (prog_done |-> !seen) else $error("twice");
  a_resp_excl: assert property (!(prog_done && prog_rejected)) else $error("both");
  a_no_volt: assert property
    (!prog_voltage_present [*3] ##0 prog_write |=> prog_rejected) else $error("volt");
  a_rd_idle: assert property (!$past(prog_read) |-> !prog_rdata) else $error("rdata");
  a_stop_gate: assert property
    (stop_allowed == (!watchdog_active || stop_with_watchdog_ext_control && nmi_pin))
    else $error("stop");
  a_opt_hold: assert property
    (arst_n [*7] |-> $stable(stop_with_watchdog_ext_control)) else $error("hold");
  c_done: cover property (prog_done);
  c_nak: cover property (prog_rejected);
  c_stop: cover property (watchdog_active && stop_allowed);
endmodule
bind option_byte_configuration option_cfg_chk u_option_cfg_chk (.*);
`default_nettype wire

// ### bench/option_byte_configuration_tb.sv
// Self-checking bench for the option word block.
`timescale 1ns/1ps
`default_nettype none
module option_byte_configuration_tb;
  import option_cfg_pkg::*;
  logic mclk = 0, arst_n = 0, rd = 0, wdg = 0, nmi = 0, ok;
  logic [15:0] m = 16'h0000;
  int failures = 0, checked = 0, writes = 0;
  int unsigned x = 43;
  wire vpp, wr, done, nak, stp;
  wire [15:0] wd, rdat;
  wire [7:0] o;
  option_prog_tool u_option_prog_tool (.mclk, .vpp, .wr, .wd);
  option_byte_configuration u_option_byte_configuration (.mclk, .arst_n,
    .prog_voltage_present(vpp), .prog_write(wr), .prog_wdata(wd), .prog_read(rd),
    .prog_rdata(rdat), .prog_done(done), .prog_rejected(nak), .watchdog_active(wdg),
    .nmi_pin(nmi), .stop_allowed(stp), .stop_with_watchdog_ext_control(o[7]),
    .low_voltage_detect_enable(o[6]), .readout_protect(o[5]), .osc_rc_select(o[4]),
    .nmi_pin_pullup_enable(o[3]), .timer_pin_pullup_enable(o[2]),
    .hardware_watchdog_select(o[1]), .osc_safeguard_enable(o[0]));
  task automatic chk(string n, logic [15:0] e, s);
    checked++;
    if (s !== e) $display("ERROR %s exp %h got %h", n, e, s);
    failures += int'(s !== e);
  endtask
  task automatic give_verdict;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic rst;
    @(negedge mclk) arst_n = 0;
    repeat (12) @(negedge mclk);
    arst_n = 1;
    repeat (5) @(negedge mclk);
  endtask
  // Only the first write under voltage may win, even a repeat is refused.
  task automatic burn(logic [15:0] v, logic on);
    ok = on && writes++ == 0;
    u_option_prog_tool.burn(v, on);
    if (ok) m = v & ~RESERVED_ZERO_MASK | RESERVED_ONE_MASK;
    chk("resp", {ok, !ok}, {done, nak});
    $display("write test done");
  endtask
  task automatic stops;
    for (int i = 0; i < 4; i++)
    begin
      @(negedge mclk) {wdg, nmi} = i[1:0];
      #1 chk("stop", !wdg || m[9] && nmi, stp);
    end
    $display("stop test done");
  endtask
  initial forever #2.5 mclk = ~mclk;
  initial
  begin
    #9000 failures++;
    give_verdict;
  end
  initial
  begin
    rst;
    chk("blank", 0, o);
    stops;
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    burn(x[15:0], 0);
    burn(x[15:0] | 16'h0200, 1);
    chk("held", 0, o);
    burn(x[15:0], 1);
    rst;
    chk("opts", {m[9:6], m[3:0]}, o);
    stops;
    @(negedge mclk) rd = 1;
    @(negedge mclk) chk("read", m, rdat);
    $display("read test done");
    give_verdict;
  end
endmodule
`default_nettype wire
